/* File: bench/bsr_slave_model.sv */
// Behavioural model of the system controller's SPI slave (mode 0, MSB first).
// Assumes the master raises sclk only while select_low is low.
`timescale 1ns/1ps
module bsr_slave_model (
  input  wire logic         sclk_in,
  input  wire logic         select_low_in,
  input  wire logic         mosi_in,
  input  wire logic [271:0] frame_in,
  input  wire logic [7:0]   lag_ns_in,
  output logic              miso_out,
  output logic [16:0][15:0] mosi_words_out
);
  int          bit_idx;
  logic [15:0] shift_in;

  initial begin
    miso_out       = 1'b0;
    bit_idx        = 0;
    shift_in       = 16'h0000;
    mosi_words_out = '0;
  end

  // ********************************************************************
  // Frame transfer
  // ********************************************************************
  always @(negedge select_low_in) begin
    bit_idx  = 0;
    miso_out = frame_in[271];
  end

  always @(posedge sclk_in) begin
    if (select_low_in === 1'b0 && bit_idx < 272) begin
      shift_in = {shift_in[14:0], mosi_in};
      if (bit_idx % 16 == 15) begin
        mosi_words_out[bit_idx / 16] = shift_in;
      end
    end
  end

  // The line shows garbage during the lag, so a master sampling early fails.
  always @(negedge sclk_in) begin
    if (select_low_in === 1'b0) begin
      bit_idx  = bit_idx + 1;
      miso_out = ~miso_out;
      #(lag_ns_in);
      if (bit_idx < 272 && select_low_in === 1'b0) begin
        miso_out = frame_in[271 - bit_idx];
      end
    end
  end

  // Released line has no pull, so it shows the inverse of the last value.
  always @(posedge select_low_in) begin
    miso_out = ~miso_out;
  end
endmodule

/* File: bench/test_bsr_reader.sv */
// Self-checking testbench of the board status reader.
// Assumes the design package, design and slave model are compiled first.
`timescale 1ns/1ps
module test_bsr_reader;
  import bsr_pkg::*;
  localparam int GAP      = 50;
  localparam int WAIT_MAX = 15000;
  localparam logic [271:0] FRAME_A = {16'h000A, 16'h0001, 16'h2DFF, 16'h05DC, 16'h0334,
    16'h0A6F, 16'h0333, 16'h01CA, 16'h0AAA, 16'h0A14, 16'h002C, 16'h0029, 16'h0028,
    16'h0029, 16'h0028, 16'h002A, 16'hFFFF};
  localparam logic [271:0] FRAME_B = {FRAME_A[255:0], 16'h5A50};

  logic              clk_sys = 1'b0;
  logic              rst     = 1'b1;
  logic              miso;
  logic [271:0]      frame   = FRAME_A;
  logic [7:0]        lag     = 8'h00;
  logic [16:0][15:0] mosi_words;
  logic [271:0]      prev_status;
  bsr_spi_out_t      spi;
  bsr_board_status_t status;
  logic              updated;
  int                failures = 0;
  int                checked  = 0;

  always #2.5 clk_sys = ~clk_sys;

  bsr_reader #(.POLL_GAP(GAP)) uut (
    .CLK_SYS_IN         (clk_sys),
    .RST_IN             (rst),
    .SPI_MISO_IN        (miso),
    .SPI_OUT            (spi),
    .STATUS_OUT         (status),
    .STATUS_UPDATED_OUT (updated)
  );

  bsr_slave_model slave (
    .sclk_in        (spi.sclk),
    .select_low_in  (spi.select_low),
    .mosi_in        (spi.mosi),
    .frame_in       (frame),
    .lag_ns_in      (lag),
    .miso_out       (miso),
    .mosi_words_out (mosi_words)
  );

  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic [271:0] expect_of(input logic [271:0] f);
    return {f[271:16], f[15:0] & PIN_KEEP_MASK};
  endfunction

  task automatic check(input string name, input logic [271:0] exp, input logic [271:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_level(input string name, input bit on_flag, input logic level,
                            input int limit);
    int n;
    n = 0;
    while (((on_flag ? updated : spi.select_low) !== level) && n < limit) begin
      @(negedge clk_sys);
      n++;
    end
    check(name, level, on_flag ? updated : spi.select_low);
  endtask

  task automatic check_idle();
    check("sclk", 1'b0, spi.sclk);
    check("select_low", 1'b1, spi.select_low);
    check("mosi", 1'b0, spi.mosi);
    check("status", '0, status);
    check("updated", 1'b0, updated);
  endtask

  task automatic test_done();
    $display("Totals: failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ********************************************************************
  // Monitor, watchdog and main sequence
  // ********************************************************************
  // Status may only move between frames, never while bits arrive.
  always @(negedge clk_sys) begin
    if (!rst && spi.select_low === 1'b1 && spi.sclk !== 1'b0) begin
      failures++;
      $display("BAD sclk_idle expected 0 seen %b", spi.sclk);
    end
    if (!rst && spi.select_low === 1'b0 && status !== prev_status) begin
      failures++;
      $display("BAD status_frozen expected %h seen %h", prev_status, status);
    end
    prev_status = status;
  end

  initial begin
    repeat (80000) @(posedge clk_sys);
    failures++;
    $display("BAD watchdog expected done seen timeout");
    test_done();
  end

  initial begin
    repeat (16) @(negedge clk_sys);
    check_idle();
    rst = 1'b0;
    wait_level("poll_start", 1'b0, 1'b0, 4);
    check("updated_at_start", 1'b0, updated);
    wait_level("updated", 1'b1, 1'b1, WAIT_MAX);
    check("status_a", expect_of(FRAME_A), status);
    for (int i = 0; i < FRAME_WORDS; i++) begin
      check("mosi_word", i, mosi_words[i]);
    end
    frame = FRAME_B;
    lag   = 8'h28;
    wait_level("repoll", 1'b0, 1'b0, GAP + 8);
    check("updated_drop", 1'b0, updated);
    check("status_held", expect_of(FRAME_A), status);
    wait_level("updated", 1'b1, 1'b1, WAIT_MAX);
    check("status_b", expect_of(FRAME_B), status);
    // A reset in mid-frame must abandon the transfer cleanly.
    wait_level("repoll", 1'b0, 1'b0, GAP + 8);
    repeat (3000) @(negedge clk_sys);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    check_idle();
    rst = 1'b0;
    wait_level("poll_restart", 1'b0, 1'b0, 4);
    wait_level("updated", 1'b1, 1'b1, WAIT_MAX);
    check("status_after_reset", expect_of(FRAME_B), status);
    test_done();
  end
endmodule

/* File: hdl/bsr_pkg.sv */
// Constants, field layouts and carrier types of the board status reader.
// Assumes a single system clock of 200 MHz shared with the user logic.
package bsr_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_PERIOD_PS    = 5000;
  localparam int SCLK_HALF_NS     = 100;
  localparam int SCLK_HALF_CYCLES =
    ((SCLK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1) ? 1 :
    (SCLK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int POLL_GAP_US      = 1000;
  localparam int POLL_GAP_CYCLES  = POLL_GAP_US * (1000000 / CLK_PERIOD_PS);

  // ********************************************************************
  // Frame layout
  // ********************************************************************
  localparam int          WORD_BITS       = 16;
  localparam int          FRAME_WORDS     = 17;
  localparam int          FIFO_DEPTH      = 32;
  localparam logic [15:0] PIN_KEEP_MASK   = 16'h00AF;
  localparam logic [15:0] STATUS_WORD_RST = 16'h0000;

  typedef struct packed {
    logic [7:0] reserved_hi;
    logic       fan_alert_low;
    logic       reserved_6;
    logic       shutdown_low;
    logic       reserved_4;
    logic       flash_page_indication;
    logic       configuration_success;
    logic       configuration_failure_low;
    logic       configuration_in_progress_low;
  } bsr_pin_status_t;

  // Word 0 of the frame sits in the most significant position.
  typedef struct packed {
    logic [15:0]     board_version;
    logic [15:0]     controller_firmware_revision;
    logic [15:0]     input_supply_millivolts;
    logic [15:0]     input_supply_milliamps;
    logic [15:0]     core_millivolts;
    logic [15:0]     core_milliamps;
    logic [15:0]     core2_millivolts;
    logic [15:0]     core2_milliamps;
    logic [15:0]     fan1_rpm;
    logic [15:0]     fan2_rpm;
    logic [15:0]     board_celsius;
    logic [15:0]     board2_celsius;
    logic [15:0]     die_celsius;
    logic [15:0]     secure_manager_celsius;
    logic [15:0]     transceiver_a_celsius;
    logic [15:0]     transceiver_b_celsius;
    bsr_pin_status_t pin_status;
  } bsr_board_status_t;

  typedef struct packed {
    logic sclk;
    logic select_low;
    logic mosi;
  } bsr_spi_out_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_SHIFT  = 3'b011,
    ST_PUSH   = 3'b010,
    ST_COMMIT = 3'b110
  } bsr_state_t;

endpackage

/* File: hdl/bsr_reader.sv */
// Board status reader: an SPI master that polls the system controller and
// presents the returned frame as parallel status words.
// Assumes MISO comes from another chip and needs synchronising.
`timescale 1ns/1ps

// ********************************************************************
// Word FIFO between the serial receiver and the frame assembler
// ********************************************************************
module bsr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0]      count_reg, count_next;
  logic             push, pop;
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("FIFO depth must be a power of two of at least 2.");
  end

  assign in_ready_out  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem[rd_ptr_reg];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb begin
    wr_ptr_next = push ? wr_ptr_reg + AW'(1) : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + AW'(1) : rd_ptr_reg;
    count_next  = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end
endmodule

module bsr_reader #(
  parameter int POLL_GAP = bsr_pkg::POLL_GAP_CYCLES
) (
  input  wire logic                       CLK_SYS_IN,
  input  wire logic                       RST_IN,
  input  wire logic                       SPI_MISO_IN,
  output bsr_pkg::bsr_spi_out_t           SPI_OUT,
  output bsr_pkg::bsr_board_status_t      STATUS_OUT,
  output logic                            STATUS_UPDATED_OUT
);
  import bsr_pkg::*;

  // ********************************************************************
  // State
  // ********************************************************************
  bsr_state_t        state_reg, state_next;
  logic [15:0]       div_reg, div_next;
  logic [31:0]       gap_reg, gap_next;
  logic [4:0]        bit_reg, bit_next;
  logic [4:0]        word_reg, word_next;
  logic [15:0]       shift_reg, shift_next;
  bsr_spi_out_t      spi_reg, spi_next;
  logic              valid_reg, valid_next;
  bsr_board_status_t status_reg, status_next;
  logic [4:0]        fill_reg, fill_next;
  logic [15:0]       stage_reg [FRAME_WORDS];
  logic              miso_meta_reg, miso_sync_reg;
  logic              tick, fifo_in_ready, fifo_out_valid, drain_ready;
  logic [15:0]       fifo_out_data;
  logic [FRAME_WORDS*16-1:0] stage_flat;

  if (POLL_GAP < 1 || FRAME_WORDS > 31 || FRAME_WORDS > FIFO_DEPTH) begin : g_check
    $error("Poll gap or frame length out of range.");
  end

  // The first stage only feeds the second; metastability stays there.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      miso_meta_reg <= 1'b0;
      miso_sync_reg <= 1'b0;
    end else begin
      miso_meta_reg <= SPI_MISO_IN;
      miso_sync_reg <= miso_meta_reg;
    end
  end

  // Half-period enable derived from the system clock.
  assign tick = (div_reg == 16'h0000);

  // ********************************************************************
  // Sequencer
  // ********************************************************************
  always_comb begin
    state_next  = state_reg;
    div_next    = tick ? 16'(SCLK_HALF_CYCLES - 1) : div_reg - 16'h0001;
    gap_next    = gap_reg;
    bit_next    = bit_reg;
    word_next   = word_reg;
    shift_next  = shift_reg;
    spi_next    = spi_reg;
    valid_next  = valid_reg;
    status_next = status_reg;
    fill_next   = (fifo_out_valid && drain_ready) ? fill_reg + 5'h01 : fill_reg;
    case (state_reg)
      ST_IDLE: begin
        if (gap_reg == 32'h0000_0000) begin
          valid_next          = 1'b0;
          spi_next.select_low = 1'b0;
          shift_next          = 16'h0000;
          spi_next.mosi       = 1'b0;
          word_next           = 5'h00;
          div_next            = 16'(SCLK_HALF_CYCLES - 1);
          state_next          = ST_SETUP;
        end else begin
          gap_next = gap_reg - 32'h0000_0001;
        end
      end
      ST_SETUP: begin
        if (tick) begin
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (tick) begin
          if (!spi_reg.sclk) begin
            spi_next.sclk = 1'b1;
            shift_next    = {shift_reg[14:0], miso_sync_reg};
          end else begin
            spi_next.sclk = 1'b0;
            bit_next      = bit_reg + 5'h01;
            if (bit_reg == 5'h0F) begin
              state_next = ST_PUSH;
            end else begin
              spi_next.mosi = shift_reg[15];
            end
          end
        end
      end
      ST_PUSH: begin
        // A full FIFO holds the link here with SCLK parked low.
        if (fifo_in_ready) begin
          bit_next = 5'h00;
          if (word_reg == 5'(FRAME_WORDS - 1)) begin
            spi_next.select_low = 1'b1;
            state_next          = ST_COMMIT;
          end else begin
            word_next     = word_reg + 5'h01;
            shift_next    = {11'h000, word_reg + 5'h01};
            spi_next.mosi = 1'b0;
            div_next      = 16'(SCLK_HALF_CYCLES - 1);
            state_next    = ST_SHIFT;
          end
        end
      end
      ST_COMMIT: begin
        if (!fifo_out_valid && fill_reg == 5'(FRAME_WORDS)) begin
          status_next = bsr_board_status_t'(stage_flat);
          status_next.pin_status = bsr_pin_status_t'(stage_reg[FRAME_WORDS-1]
                                   & PIN_KEEP_MASK);
          valid_next  = 1'b1;
          fill_next   = 5'h00;
          gap_next    = 32'(POLL_GAP - 1);
          state_next  = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      state_reg  <= ST_IDLE;
      div_reg    <= 16'h0000;
      gap_reg    <= 32'h0000_0000;
      bit_reg    <= 5'h00;
      word_reg   <= 5'h00;
      shift_reg  <= 16'h0000;
      spi_reg    <= '{sclk: 1'b0, select_low: 1'b1, mosi: 1'b0};
      valid_reg  <= 1'b0;
      status_reg <= {FRAME_WORDS{STATUS_WORD_RST}};
      fill_reg   <= 5'h00;
    end else begin
      state_reg  <= state_next;
      div_reg    <= div_next;
      gap_reg    <= gap_next;
      bit_reg    <= bit_next;
      word_reg   <= word_next;
      shift_reg  <= shift_next;
      spi_reg    <= spi_next;
      valid_reg  <= valid_next;
      status_reg <= status_next;
      fill_reg   <= fill_next;
    end
  end

  // ********************************************************************
  // Word buffer and frame assembly
  // ********************************************************************
  bsr_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (CLK_SYS_IN),
    .rst_in        (RST_IN),
    .in_valid_in   (state_reg == ST_PUSH),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (shift_reg),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (drain_ready),
    .out_data_out  (fifo_out_data)
  );

  // Words beyond a frame wait in the FIFO until the frame is committed.
  assign drain_ready = (fill_reg < 5'(FRAME_WORDS));

  always_ff @(posedge CLK_SYS_IN) begin
    if (fifo_out_valid && drain_ready) begin
      stage_reg[fill_reg] <= fifo_out_data;
    end
  end

  for (genvar i = 0; i < FRAME_WORDS; i++) begin : g_flat
    assign stage_flat[(FRAME_WORDS-1-i)*16 +: 16] = stage_reg[i];
  end

  assign SPI_OUT            = spi_reg;
  assign STATUS_OUT         = status_reg;
  assign STATUS_UPDATED_OUT = valid_reg;

  // ********************************************************************
  // Checks
  // ********************************************************************
  a_reset_idle: assert property (@(posedge CLK_SYS_IN)
    $past(RST_IN) && !RST_IN |-> !valid_reg && spi_reg.select_low && !spi_reg.sclk)
    else $error("Reset did not return the reader to idle.");
  a_auto_start: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    state_reg == ST_IDLE && gap_reg == 32'h0000_0000 |=> !spi_reg.select_low)
    else $error("Poll did not start when the gap expired.");
  a_valid_cause: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    $rose(valid_reg) |-> $past(state_reg) == ST_COMMIT && $past(fill_reg) == 5'(FRAME_WORDS))
    else $error("Updated flag rose without a complete frame.");
  a_mosi_steady: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    spi_reg.sclk && $past(spi_reg.sclk) |-> $stable(spi_reg.mosi))
    else $error("MOSI changed while SCLK was high.");
  a_select_scope: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    spi_reg.select_low |-> !spi_reg.sclk && state_reg inside {ST_IDLE, ST_SETUP, ST_COMMIT})
    else $error("SCLK toggled or transfer ran outside select.");
  a_pin_reserved: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    (status_reg.pin_status & ~PIN_KEEP_MASK) == 16'h0000)
    else $error("Reserved pin status bits not zero.");
  a_flag_drop: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    $fell(spi_reg.select_low) |-> !valid_reg ##1 !valid_reg)
    else $error("Updated flag still high during a poll.");
  a_status_once: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    !$past(RST_IN) && !$stable(status_reg) |-> $rose(valid_reg) && $past(state_reg) == ST_COMMIT)
    else $error("Status changed outside the frame commit.");
  a_push_stall: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    state_reg == ST_PUSH |=> !spi_reg.sclk && ((state_reg == ST_PUSH) != $past(fifo_in_ready)))
    else $error("Word push did not follow FIFO space.");
endmodule
